// ===== logic/kfe_tx_encoder.sv
// Backplane forward error correction transmit path: input FIFO, transcoder,
// cyclic parity encoder, frame scrambler, bypass and error injector.
// Assumes one 66-bit block per beat and control inputs from same-clock registers.
//
// How it works
// - Transcode bit is lower sync XOR data55
// - Thirty-two blocks repack into thirty-two words
// - Parity is x32 message modulo generator
// - Frame is message then 32 parity bits
// - Scrambler is 58-bit 1+x39+x58 generator
// - Scrambler reseeded at every frame start
// - Scrambler XORed onto frame, no latency
// - Coding off routes PCS data unchanged
// - Injector follows scrambler and bypass mux
// - Mask XORed once per period+1 66-bit words
// - Zero period continuous, else that gap
// - Injector adds one 66-bit-word register
// - One clock and one reset only
// - Receive bypass passes with zero latency
// - Coding off after reset, 10G non-WAN
`timescale 1ns/1ns
`include "kfe_defs.svh"

module kfe_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_r];
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
  // Flags are registered so both ready and valid leave from flip-flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_r <= push ? AW'(wr_r + 1'b1) : wr_r;
      rd_r <= pop ? AW'(rd_r + 1'b1) : rd_r;
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt != (AW+1)'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule : kfe_fifo

module kfe_tx_encoder #(
  parameter int FIFO_DEPTH = `KFE_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control bits from the management registers
  input wire kfe_pkg::kfe_ctl_s ctl,
  input wire kfe_pkg::kfe_inj_s inj,
  // Scrambled blocks from the PCS
  input wire kfe_pkg::kfe_blk_s pcs_blk,
  input wire logic pcs_valid,
  output logic pcs_ready,
  // Words toward the serializer
  output logic [`KFE_BLK_W-1:0] tx_word,
  output logic tx_valid,
  output logic tx_frame_start,
  input wire logic tx_ready,
  // Receive side bypass
  input wire logic [`KFE_BLK_W-1:0] rx_in_word,
  output logic [`KFE_BLK_W-1:0] rx_out_word
);
  // Cyclic parity over the first n bits of a word, most significant first
  function automatic logic [`KFE_PAR_W-1:0] crc_word(
    input logic [`KFE_PAR_W-1:0] st,
    input logic [`KFE_BLK_W-1:0] w,
    input int n
  );
    logic fb;
    logic [`KFE_PAR_W-1:0] s;
    fb = 1'b0;
    s = st;
    for (int i = 0; i < `KFE_BLK_W; i++) begin
      if (i < n) begin
        fb = w[`KFE_BLK_W-1-i] ^ s[`KFE_PAR_W-1];
        s = {s[`KFE_PAR_W-2:0], 1'b0} ^ (fb ? `KFE_GEN_POLY : '0);
      end
    end
    return s;
  endfunction : crc_word

  // One word of scrambler sequence, returned as {next state, sequence}
  function automatic logic [`KFE_SCR_W+`KFE_BLK_W-1:0] pn_word(
    input logic [`KFE_SCR_W-1:0] st
  );
    logic b;
    logic [`KFE_SCR_W-1:0] s;
    logic [`KFE_BLK_W-1:0] pn;
    b = 1'b0;
    s = st;
    pn = '0;
    for (int i = 0; i < `KFE_BLK_W; i++) begin
      b = s[`KFE_SCR_TAP_A] ^ s[`KFE_SCR_TAP_B];
      pn[`KFE_BLK_W-1-i] = b;
      s = {s[`KFE_SCR_W-2:0], b};
    end
    return {s, pn};
  endfunction : pn_word

  // Reset release low holds all coding state, as if reset
  // rst or reset release low, merged into one reset
  logic core_rst;
  assign core_rst = rst || !ctl.reset_release;

  assign rx_out_word = rx_in_word;

  kfe_pkg::kfe_blk_s q_blk;
  logic q_valid;
  logic q_ready;
  kfe_fifo #(
    .WIDTH(`KFE_BLK_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(core_rst),
    .in_data(pcs_blk),
    .in_valid(pcs_valid),
    .in_ready(pcs_ready),
    .out_data(q_blk),
    .out_valid(q_valid),
    .out_ready(q_ready)
  );

  logic [`KFE_CNT_W-1:0] cnt_r;
  logic [`KFE_MSG_W-1:0] res_r;
  logic [`KFE_PAR_W-1:0] par_r;
  logic [`KFE_SCR_W-1:0] scr_r;
  logic en_r;
  logic have_prev_r;
  logic [`KFE_BLK_W-1:0] st_word_r;
  logic st_valid_r;
  logic st_start_r;
  logic [`KFE_PAR_W-1:0] gap_r;

  // Pipeline moves as one; output stall backs up into the FIFO
  logic adv;
  logic st_adv;
  logic pop;
  assign adv = !tx_valid || tx_ready;
  assign st_adv = adv && ctl.clock_enable;
  assign q_ready = st_adv;
  assign pop = q_valid && st_adv;

  // coding only at 10G outside WAN mode
  logic coding_req;
  logic mode_on;
  logic at_wrap;
  assign coding_req = ctl.coding_enable && ctl.rate_10g && !ctl.wan_mode;
  assign at_wrap = cnt_r == '0;
  assign mode_on = at_wrap ? coding_req : en_r;

  logic tbit;
  logic [`KFE_MSG_W-1:0] msg;
  assign tbit = q_blk.sync[0] ^ q_blk.data[`KFE_TBIT_SRC];
  assign msg = {tbit, q_blk.data};

  // repack with carried residue
  // Residue length reaches 66, so two bits wider than the counter
  logic [`KFE_CNT_W+1:0] res_len;
  logic [2*`KFE_MSG_W-1:0] cat;
  logic [`KFE_BLK_W-1:0] pack_word;
  assign res_len = (`KFE_CNT_W+2)'(`KFE_BLK_W) - (`KFE_CNT_W+2)'(cnt_r);
  assign cat = {res_r, `KFE_MSG_W'(0)} | ({msg, `KFE_MSG_W'(0)} >> res_len);
  assign pack_word = cat[2*`KFE_MSG_W-1 -: `KFE_BLK_W];

  // parity over message bits of this word
  logic [`KFE_PAR_W-1:0] par_base;
  logic [`KFE_PAR_W-1:0] par_next;
  logic [`KFE_TAIL_W-1:0] tail_bits;
  assign par_base = (cnt_r == `KFE_FIRST_WORD) ? '0 : par_r;
  assign tail_bits = res_r[`KFE_MSG_W-1 -: `KFE_TAIL_W];
  assign par_next = at_wrap ?
    crc_word(par_r, {tail_bits, `KFE_PAR_W'(0)}, `KFE_TAIL_W) :
    crc_word(par_base, pack_word, `KFE_BLK_W);

  // last word carries parity at the end
  logic [`KFE_BLK_W-1:0] enc_word;
  assign enc_word = at_wrap ? {tail_bits, par_next} : pack_word;

  // seed at the first word of a frame
  logic frame_first;
  logic [`KFE_SCR_W-1:0] scr_base;
  logic [`KFE_SCR_W+`KFE_BLK_W-1:0] pn_all;
  assign frame_first = cnt_r == `KFE_FIRST_WORD;
  assign scr_base = frame_first ? `KFE_SCR_SEED : scr_r;
  assign pn_all = pn_word(scr_base);

  logic [`KFE_BLK_W-1:0] sel_word;
  logic sel_valid;
  assign sel_word = mode_on ? (enc_word ^ pn_all[`KFE_BLK_W-1:0]) : q_blk;
  assign sel_valid = mode_on ? (!at_wrap || have_prev_r) : 1'b1;

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      cnt_r <= '0;
      res_r <= '0;
      par_r <= '0;
      scr_r <= `KFE_SCR_SEED;
      en_r <= 1'b0;
      have_prev_r <= 1'b0;
    end else if (pop) begin
      en_r <= mode_on;
      if (mode_on) begin
        cnt_r <= (cnt_r == `KFE_LAST_CNT) ? '0 : cnt_r + 1'b1;
        res_r <= at_wrap ? msg : {cat[`KFE_DATA_W-1:0], 1'b0};
        par_r <= at_wrap ? '0 : par_next;
        scr_r <= pn_all[`KFE_SCR_W+`KFE_BLK_W-1 -: `KFE_SCR_W];
        have_prev_r <= 1'b1;
      end else begin
        cnt_r <= '0;
        have_prev_r <= 1'b0;
      end
    end
  end

  // Coding stage register ahead of the injector
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      st_word_r <= '0;
      st_valid_r <= 1'b0;
      st_start_r <= 1'b0;
    end else if (st_adv) begin
      st_word_r <= sel_word;
      st_valid_r <= pop && sel_valid;
      st_start_r <= pop && mode_on && frame_first;
    end
  end

  logic inj_now;
  logic [`KFE_BLK_W-1:0] inj_word;
  assign inj_now = gap_r == '0;
  assign inj_word = st_word_r ^ {`KFE_TAIL_W'(0), inj_now ? inj.mask : `KFE_PAR_W'(0)};

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      gap_r <= '0;
    end else if (st_adv && st_valid_r) begin
      gap_r <= inj_now ? inj.period : gap_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      tx_word <= '0;
      tx_valid <= 1'b0;
      tx_frame_start <= 1'b0;
    end else if (st_adv) begin
      tx_word <= inj_word;
      tx_valid <= st_valid_r;
      tx_frame_start <= st_valid_r && st_start_r;
    end
  end
endmodule : kfe_tx_encoder

// ===== logic/kfe_defs.svh
// Constants for the backplane coding transmit encoder.
// Included by the package and the design file; definitions only.
`ifndef KFE_DEFS_SVH
`define KFE_DEFS_SVH
`define KFE_BLK_W 66
`define KFE_DATA_W 64
`define KFE_MSG_W 65
`define KFE_PAR_W 32
`define KFE_TAIL_W 34
`define KFE_BLKS 32
`define KFE_CNT_W 5
`define KFE_LAST_CNT 5'h1f
`define KFE_FIRST_WORD 5'h01
`define KFE_TBIT_SRC 55
`define KFE_GEN_POLY 32'h00a00805
`define KFE_SCR_W 58
`define KFE_SCR_TAP_A 57
`define KFE_SCR_TAP_B 38
`define KFE_SCR_SEED 58'h2aaaaaaaaaaaaaa
`define KFE_FIFO_DEPTH 32
`endif

// ===== logic/kfe_pkg.sv
// Types shared by the backplane coding transmit encoder.
// Assumes kfe_defs.svh is on the include path.
`include "kfe_defs.svh"
package kfe_pkg;
  typedef struct packed {
    logic [1:0] sync;
    logic [`KFE_DATA_W-1:0] data;
  } kfe_blk_s;
  typedef struct packed {
    logic [`KFE_PAR_W-1:0] mask;
    logic [`KFE_PAR_W-1:0] period;
  } kfe_inj_s;
  typedef struct packed {
    logic coding_enable;
    logic clock_enable;
    logic reset_release;
    logic rate_10g;
    logic wan_mode;
  } kfe_ctl_s;
endpackage : kfe_pkg

// ===== testbench/kfe_tx_encoder_chk.sv
// Port checker for the transmit encoder.
// Assumes it is bound into kfe_tx_encoder.
`timescale 1ns/1ns
`include "kfe_defs.svh"
module kfe_tx_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire kfe_pkg::kfe_ctl_s ctl,
  input wire logic pcs_ready,
  input wire logic [`KFE_BLK_W-1:0] tx_word,
  input wire logic tx_valid,
  input wire logic tx_frame_start,
  input wire logic tx_ready,
  input wire logic [`KFE_BLK_W-1:0] rx_in_word,
  input wire logic [`KFE_BLK_W-1:0] rx_out_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rx_pass; rx_out_word == rx_in_word; endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx bypass differs");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_word); endproperty
  a_hold: assert property (p_hold) else $error("word dropped in stall");
  property p_freeze;
    ctl.reset_release && !ctl.clock_enable |=> $stable(tx_word) && $stable(tx_valid);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while clock off");
  property p_rel_valid; !ctl.reset_release |=> !tx_valid && !tx_frame_start; endproperty
  a_rel_valid: assert property (p_rel_valid) else $error("valid in reset");
  property p_rel_ready; !ctl.reset_release |=> !pcs_ready; endproperty
  a_rel_ready: assert property (p_rel_ready) else $error("ready in reset");
  property p_rel_word; !ctl.reset_release |=> tx_word == '0; endproperty
  a_rel_word: assert property (p_rel_word) else $error("word not cleared");
  property p_fs_valid; tx_frame_start |-> tx_valid; endproperty
  a_fs_valid: assert property (p_fs_valid) else $error("start without valid");
  property p_fs_once;
    tx_frame_start && tx_ready && ctl.clock_enable |=> !tx_frame_start;
  endproperty
  a_fs_once: assert property (p_fs_once) else $error("two frame starts");
endmodule : kfe_tx_chk
bind kfe_tx_encoder kfe_tx_chk u_chk (.ref_clk(ref_clk), .rst(rst), .ctl(ctl),
  .pcs_ready(pcs_ready), .tx_word(tx_word), .tx_valid(tx_valid),
  .tx_frame_start(tx_frame_start), .tx_ready(tx_ready), .rx_in_word(rx_in_word),
  .rx_out_word(rx_out_word));

// ===== testbench/kfe_pcs_model.sv
// PCS source model offering numbered blocks.
// Assumes a ready/valid sink on the same clock.
`timescale 1ns/1ns
module kfe_pcs_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pacing
  input wire logic slow,
  input wire logic [15:0] lim,
  // Block stream
  input wire logic pcs_ready,
  output kfe_pkg::kfe_blk_s pcs_blk,
  output logic pcs_valid
);
  logic [15:0] n = 16'h0000;
  logic tk = 1'b0;
  logic t = 1'b0;
  initial pcs_valid = 1'b0;
  initial pcs_blk = '0;
  always @(posedge ref_clk) begin
    tk = pcs_valid && pcs_ready;
    #1;
    t = ~t;
    n = rst ? 16'h0000 : n + {15'h0000, tk};
    // Offer held until taken; idle data keeps toggling
    if (rst || tk || !pcs_valid) begin
      pcs_valid = !rst && (n < lim) && !(slow && t);
      pcs_blk = pcs_valid ? {n[0] ? 2'b10 : 2'b01, {4{n}} ^ 64'h0123456789abcdef} : ~pcs_blk;
    end
  end
endmodule : kfe_pcs_model

// ===== testbench/testbench.sv
// Self-checking bench: bypass words, injection, stalls and frame count.
// Assumes the PCS model feeds the encoder.
`timescale 1ns/1ns
`include "kfe_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin errors++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  kfe_pkg::kfe_ctl_s ctl = '0;
  kfe_pkg::kfe_inj_s inj = '0;
  kfe_pkg::kfe_blk_s pcs_blk;
  logic pcs_valid, pcs_ready, tx_valid, tx_frame_start;
  logic tx_ready = 1'b1;
  logic slow = 1'b0;
  logic coding = 1'b0;
  logic [15:0] lim = 16'h0000;
  logic [`KFE_BLK_W-1:0] tx_word, rx_out_word, expw;
  logic [`KFE_BLK_W-1:0] rx_in_word = '0;
  logic [2111:0] frm = '0;
  int errors = 0, comparisons = 0, words = 0, since = 0, starts = 0;
  initial forever #2 ref_clk = ~ref_clk;
  kfe_tx_encoder #(.FIFO_DEPTH(4)) dut (.ref_clk(ref_clk), .rst(rst), .ctl(ctl), .inj(inj),
    .pcs_blk(pcs_blk), .pcs_valid(pcs_valid), .pcs_ready(pcs_ready), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_frame_start(tx_frame_start), .tx_ready(tx_ready),
    .rx_in_word(rx_in_word), .rx_out_word(rx_out_word));
  kfe_pcs_model pcs (.ref_clk(ref_clk), .rst(rst), .slow(slow), .lim(lim),
    .pcs_ready(pcs_ready), .pcs_blk(pcs_blk), .pcs_valid(pcs_valid));
  function automatic logic [65:0] blk(input int n);
    blk = {n[0] ? 2'b10 : 2'b01, {4{n[15:0]}} ^ 64'h0123456789abcdef};
  endfunction : blk
  // Reference frame: transcode, divide, append parity, then scramble all 2112 bits
  function automatic logic [2111:0] frame(input int f);
    logic [2111:0] fr;
    logic [31:0] p;
    logic [57:0] s;
    logic [65:0] b;
    logic fb;
    fr = '0;
    p = '0;
    s = `KFE_SCR_SEED;
    for (int i = 0; i < 32; i++) begin
      b = blk(32 * f + i);
      fr[2111-65*i -: 65] = {b[64] ^ b[55], b[63:0]};
    end
    for (int i = 0; i < 2080; i++) begin
      fb = fr[2111-i] ^ p[31];
      p = {p[30:0], 1'b0} ^ (fb ? `KFE_GEN_POLY : 32'h00000000);
    end
    fr[31:0] = p;
    for (int i = 0; i < 2112; i++) begin
      fb = s[57] ^ s[38];
      fr[2111-i] = fr[2111-i] ^ fb;
      s = {s[56:0], fb};
    end
    return fr;
  endfunction : frame
  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1 && ctl.clock_enable === 1'b1) begin
      expw = blk(words) ^ ((words % (inj.period + 1)) == 0 ? {34'h0, inj.mask} : 66'h0);
      if (!coding) `CHK("tx_word", expw, tx_word)
      if (coding && words % 32 == 0) frm = frame(words / 32);
      if (coding) `CHK("coded_word", frm[2111-66*(words%32) -: 66], tx_word)
      if (coding) `CHK("frame_start", words % 32 == 0, tx_frame_start)
      if (coding && tx_frame_start === 1'b1) begin
        if (starts > 0) `CHK("frame_len", 32, since)
        starts++;
        since = 0;
      end
      words++;
      since++;
    end
  end
  task automatic run(input kfe_pkg::kfe_ctl_s c, input kfe_pkg::kfe_inj_s j, input int n,
                     input logic s);
    int k;
    int e;
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    ctl = '0;
    lim = 16'h0000;
    inj = j;
    slow = s;
    coding = c.coding_enable && c.rate_10g && !c.wan_mode;
    e = coding ? n - 1 : n;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    words = 0;
    starts = 0;
    @(posedge ref_clk);
    #1;
    ctl.clock_enable = 1'b1;
    @(posedge ref_clk);
    #1;
    ctl.reset_release = 1'b1;
    @(posedge ref_clk);
    #1;
    ctl = c;
    lim = 16'(n);
    rx_in_word = blk(n);
    if (!s) begin
      tx_ready = 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
      `CHK("pcs_ready", 1'b0, pcs_ready)
      tx_ready = 1'b1;
      ctl.clock_enable = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      ctl.clock_enable = 1'b1;
    end
    `CHK("rx_out_word", blk(n), rx_out_word)
    for (k = 0; k < 3000 && words < e; k++) @(posedge ref_clk);
    #1;
    `CHK("word_count", e, words)
    if (coding) `CHK("frames", 3, starts)
  endtask : run
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    // wan and low rate keep bypass
    run(5'b11111, {32'h0000000f, 32'h00000000}, 20, 1'b0);
    run(5'b11100, {32'h80000001, 32'h00000002}, 24, 1'b1);
    run(5'b11110, {32'h00000000, 32'h00000000}, 97, 1'b0);
    final_report();
  end
endmodule : testbench
